// >>> logic/spm_defines.vh
`ifndef SPM_DEFINES_VH
`define SPM_DEFINES_VH

// Register byte offsets; only address bits 11:2 are decoded.
`define SPM_OFF_CTRL      12'h500
`define SPM_OFF_STATUS    12'h504
`define SPM_OFF_XFER_LEN  12'h508
`define SPM_OFF_RX_LAST   12'h50c
`define SPM_OFF_TX_PTR    12'h544
`define SPM_OFF_TX_LIMIT  12'h548
`define SPM_OFF_TX_SENT   12'h54c
`define SPM_OFF_TX_LIST   12'h550
`define SPM_OFF_FORMAT    12'h554
`define SPM_OFF_ORC       12'h5c0

// Field positions.
`define SPM_CNT_W         14
`define SPM_CTRL_START    0
`define SPM_STAT_BUSY     0
`define SPM_FMT_ORDER     0
`define SPM_FMT_CLOCK_PHASE_SELECT      1
`define SPM_FMT_CLOCK_POLARITY_SELECT      2

// Reset values.
`define SPM_RST_PTR       32'h0000_0000
`define SPM_RST_CNT       14'h0000
`define SPM_RST_LIST      1'b0
`define SPM_RST_FMT       3'h0
`define SPM_RST_CHAR      8'h00

// Timing: serial clock period and core clock period in ns.
`define SPM_SCK_PERIOD_NS 64
`define SPM_CORE_PERIOD_NS 5
`define SPM_SCK_HALF_CYC  ((`SPM_SCK_PERIOD_NS / 2) / `SPM_CORE_PERIOD_NS)

`endif

// >>> logic/spm_master_regs.v
// Operation
// R01: Read-only count of bytes sent last transaction.
// R02: List mode: 0 single buffer, 1 array list.
// R03: Order 0 shifts most significant bit first.
// R04: Order 1 shifts least significant bit first.
// R05: Phase 0 samples leading, changes on trailing.
// R06: Phase 1 samples trailing, changes on leading.
// R07: Polarity 0 idles low, 1 idles high.
// R08: Writable over-read character sent past buffer end.
// R09: Writable limit on bytes fetched per transaction.
// R10: Writable pointer gives transmit fetch start address.
// R11: Past limit send filler, do not count.
// R12: Format applies to both paths whole transaction.
`timescale 1ns/1ps
`default_nettype none
`include "spm_defines.vh"

module spm_master_regs #(
  parameter integer HALF_CYC = `SPM_SCK_HALF_CYC
) (
  // Clock, reset and clock enable
  input  wire        i_core_clk,
  input  wire        i_rst_n,
  input  wire        i_ce,
  // AHB-Lite slave
  input  wire        i_hsel,
  input  wire [31:0] i_haddr,
  input  wire [1:0]  i_htrans,
  input  wire        i_hwrite,
  input  wire [2:0]  i_hsize,
  input  wire [31:0] i_hwdata,
  input  wire        i_hready,
  output reg  [31:0] o_hrdata,
  output wire        o_hreadyout,
  output wire        o_hresp,
  // Transmit memory read port, data one cycle after the strobe
  output reg  [31:0] o_mem_addr,
  output reg         o_mem_rd,
  input  wire [7:0]  i_mem_rdata,
  // Serial pins
  output wire        o_sck,
  output wire        o_mosi,
  output reg         o_cs_n,
  input  wire        i_miso
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_SETUP = 3'h1;
  localparam [2:0] ST_FETCH = 3'h2;
  localparam [2:0] ST_MEMW  = 3'h3;
  localparam [2:0] ST_LOAD  = 3'h4;
  localparam [2:0] ST_SHIFT = 3'h5;
  localparam [2:0] ST_NEXT  = 3'h6;
  localparam [2:0] ST_HOLD  = 3'h7;

  localparam integer CW = `SPM_CNT_W;
  localparam [31:0]  HALF_END = HALF_CYC - 1;

  // Software-visible registers.
  reg [31:0]   tx_ptr_reg;
  reg [CW-1:0] tx_limit_reg;
  reg [CW-1:0] tx_sent_reg;
  reg          tx_list_reg;
  reg [2:0]    fmt_reg;
  reg [7:0]    orc_reg;
  reg [CW-1:0] xfer_len_reg;
  reg [7:0]    rx_last_reg;

  // Copies held for the running transaction.
  reg [31:0]   act_ptr_reg;
  reg [CW-1:0] act_limit_reg;
  reg [CW-1:0] act_len_reg;
  reg [2:0]    act_fmt_reg;
  reg [7:0]    act_orc_reg;
  reg          act_list_reg;

  reg [2:0]    state_reg;
  reg [CW-1:0] idx_reg;
  reg [CW-1:0] sent_reg;
  reg          from_mem_reg;
  reg [31:0]   wait_reg;

  // AHB data-phase state.
  reg          wr_pend_reg;
  reg          wr_word_reg;
  reg [9:0]    wr_idx_reg;

  reg          miso_s1_reg;
  reg          miso_s2_reg;

  wire         sck_lead;
  wire         sck_trail;
  wire         sck_done;
  wire [7:0]   rx_data;

  function is_reg;
    input [9:0]  idx;
    input [11:0] off;
    begin
      is_reg = (idx == off[11:2]);
    end
  endfunction

  function [CW-1:0] inc_cnt;
    input [CW-1:0] c;
    begin
      inc_cnt = c + {{(CW-1){1'b0}}, 1'b1};
    end
  endfunction

  // Byte offsets are counts, so they are zero-extended onto the 32-bit pointer.
  function [31:0] ptr_add;
    input [31:0]   base;
    input [CW-1:0] ofs;
    begin
      ptr_add = base + {{(32-CW){1'b0}}, ofs};
    end
  endfunction

  wire ahb_acc  = i_hsel & i_htrans[1] & i_hready & i_ce;
  // A write lands at the edge that ends its data phase.
  wire wr_now   = wr_pend_reg & wr_word_reg & i_ce;
  wire busy     = (state_reg != ST_IDLE);
  wire wr_ctrl  = wr_now & is_reg(wr_idx_reg, `SPM_OFF_CTRL);
  // A start while a transaction runs is ignored.
  wire start    = wr_ctrl & i_hwdata[`SPM_CTRL_START] & !busy;
  wire load     = (state_reg == ST_LOAD);
  // Between frames the clock rests at the programmed polarity, so a polarity
  // change never makes an edge as select falls; inside a frame the copy rules.
  wire sck_pol  = busy ? act_fmt_reg[`SPM_FMT_CLOCK_POLARITY_SELECT] : fmt_reg[`SPM_FMT_CLOCK_POLARITY_SELECT]; // R07
  wire last_idx = (inc_cnt(idx_reg) == act_len_reg);
  wire [7:0] tx_byte = from_mem_reg ? i_mem_rdata : act_orc_reg; // R08 R11

  // A frozen block stretches every bus transfer instead of dropping it.
  assign o_hreadyout = i_ce;
  assign o_hresp     = 1'b0;

  // Narrow fields read back in the low bits; unmapped words read zero.
  function [31:0] read_word;
    input [9:0] idx;
    begin
      if (is_reg(idx, `SPM_OFF_STATUS))
        read_word = {31'h0, busy};
      else if (is_reg(idx, `SPM_OFF_XFER_LEN))
        read_word = {{(32-CW){1'b0}}, xfer_len_reg};
      else if (is_reg(idx, `SPM_OFF_RX_LAST))
        read_word = {24'h0, rx_last_reg};
      else if (is_reg(idx, `SPM_OFF_TX_PTR))
        read_word = tx_ptr_reg;
      else if (is_reg(idx, `SPM_OFF_TX_LIMIT))
        read_word = {{(32-CW){1'b0}}, tx_limit_reg};
      else if (is_reg(idx, `SPM_OFF_TX_SENT))
        read_word = {{(32-CW){1'b0}}, tx_sent_reg}; // R01
      else if (is_reg(idx, `SPM_OFF_TX_LIST))
        read_word = {31'h0, tx_list_reg};
      else if (is_reg(idx, `SPM_OFF_FORMAT))
        read_word = {29'h0, fmt_reg};
      else if (is_reg(idx, `SPM_OFF_ORC))
        read_word = {24'h0, orc_reg};
      else
        read_word = 32'h0;
    end
  endfunction

  // Bus address phase: read data is captured here so it stands in the data phase.
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_word_reg <= 1'b0;
      wr_idx_reg  <= 10'h000;
      o_hrdata    <= 32'h0;
    end else if (i_ce) begin
      wr_pend_reg <= ahb_acc & i_hwrite;
      if (ahb_acc) begin
        wr_word_reg <= (i_hsize == 3'h2);
        wr_idx_reg  <= i_haddr[11:2];
        if (!i_hwrite)
          o_hrdata <= read_word(i_haddr[11:2]);
      end
    end
  end

  // Serial input crosses into the core clock through two flip-flops.
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      miso_s1_reg <= 1'b0;
      miso_s2_reg <= 1'b0;
    end else if (i_ce) begin
      miso_s1_reg <= i_miso;
      miso_s2_reg <= miso_s1_reg;
    end
  end

  // Software writes and the transaction sequencer.
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      tx_ptr_reg    <= `SPM_RST_PTR;
      tx_limit_reg  <= `SPM_RST_CNT;
      tx_sent_reg   <= `SPM_RST_CNT;
      tx_list_reg   <= `SPM_RST_LIST;
      fmt_reg       <= `SPM_RST_FMT;
      orc_reg       <= `SPM_RST_CHAR;
      xfer_len_reg  <= `SPM_RST_CNT;
      rx_last_reg   <= `SPM_RST_CHAR;
      act_ptr_reg   <= `SPM_RST_PTR;
      act_limit_reg <= `SPM_RST_CNT;
      act_len_reg   <= `SPM_RST_CNT;
      act_fmt_reg   <= `SPM_RST_FMT;
      act_orc_reg   <= `SPM_RST_CHAR;
      act_list_reg  <= `SPM_RST_LIST;
      state_reg     <= ST_IDLE;
      idx_reg       <= `SPM_RST_CNT;
      sent_reg      <= `SPM_RST_CNT;
      from_mem_reg  <= 1'b0;
      wait_reg      <= 32'h0;
      o_mem_addr    <= 32'h0;
      o_mem_rd      <= 1'b0;
      o_cs_n        <= 1'b1;
    end else if (i_ce) begin
      o_mem_rd <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            // Settings are frozen for the whole transaction.
            act_ptr_reg   <= tx_ptr_reg;
            act_limit_reg <= tx_limit_reg;
            act_len_reg   <= xfer_len_reg;
            act_fmt_reg   <= fmt_reg; // R12
            act_orc_reg   <= orc_reg;
            act_list_reg  <= tx_list_reg;
            idx_reg       <= `SPM_RST_CNT;
            sent_reg      <= `SPM_RST_CNT;
            wait_reg      <= 32'h0;
            o_cs_n        <= 1'b0;
            state_reg     <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // Select leads the first clock edge by a full serial period plus three core cycles.
          if (wait_reg == HALF_END) begin
            wait_reg  <= 32'h0;
            state_reg <= (act_len_reg == `SPM_RST_CNT) ? ST_HOLD : ST_FETCH;
          end else begin
            wait_reg <= wait_reg + 32'h1;
          end
        end
        ST_FETCH: begin
          if (idx_reg < act_limit_reg) begin // R09
            o_mem_addr   <= ptr_add(act_ptr_reg, idx_reg); // R10
            o_mem_rd     <= 1'b1;
            from_mem_reg <= 1'b1;
          end else begin
            from_mem_reg <= 1'b0; // R11
          end
          state_reg <= ST_MEMW;
        end
        ST_MEMW: begin
          // The memory answers one cycle after the strobe.
          state_reg <= ST_LOAD;
        end
        ST_LOAD: begin
          if (from_mem_reg)
            sent_reg <= inc_cnt(sent_reg); // R11
          state_reg <= ST_SHIFT;
        end
        ST_SHIFT: begin
          if (sck_done)
            state_reg <= ST_NEXT;
        end
        ST_NEXT: begin
          rx_last_reg <= rx_data;
          idx_reg     <= inc_cnt(idx_reg);
          wait_reg    <= 32'h0;
          state_reg   <= last_idx ? ST_HOLD : ST_FETCH;
        end
        ST_HOLD: begin
          // Select stays low half a period plus two core cycles past the last edge before it rises.
          if (wait_reg == HALF_END) begin
            wait_reg    <= 32'h0;
            o_cs_n      <= 1'b1;
            tx_sent_reg <= sent_reg; // R01
            if (act_list_reg)
              tx_ptr_reg <= ptr_add(act_ptr_reg, act_limit_reg); // R02
            state_reg <= ST_IDLE;
          end else begin
            wait_reg <= wait_reg + 32'h1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          o_cs_n    <= 1'b1;
        end
      endcase

      // A software write to the pointer wins over the array-list advance.
      if (wr_now) begin
        if (is_reg(wr_idx_reg, `SPM_OFF_TX_PTR))
          tx_ptr_reg <= i_hwdata; // R10
        if (is_reg(wr_idx_reg, `SPM_OFF_TX_LIMIT))
          tx_limit_reg <= i_hwdata[CW-1:0]; // R09
        if (is_reg(wr_idx_reg, `SPM_OFF_TX_LIST))
          tx_list_reg <= i_hwdata[0]; // R02
        if (is_reg(wr_idx_reg, `SPM_OFF_FORMAT))
          fmt_reg <= i_hwdata[2:0];
        if (is_reg(wr_idx_reg, `SPM_OFF_ORC))
          orc_reg <= i_hwdata[7:0]; // R08
        if (is_reg(wr_idx_reg, `SPM_OFF_XFER_LEN))
          xfer_len_reg <= i_hwdata[CW-1:0];
      end
    end
  end

  spm_sck_gen #(
    .HALF_CYC (HALF_CYC)
  ) u_sck_gen (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_ce       (i_ce),
    .i_start    (load),
    .i_clock_polarity_select     (sck_pol), // R07 R12
    .o_sck      (o_sck),
    .o_lead     (sck_lead),
    .o_trail    (sck_trail),
    .o_done     (sck_done)
  );

  spm_shifter u_shifter (
    .i_core_clk  (i_core_clk),
    .i_rst_n     (i_rst_n),
    .i_ce        (i_ce),
    .i_load      (load),
    .i_data      (tx_byte),
    .i_lsb_first (act_fmt_reg[`SPM_FMT_ORDER]), // R03 R04 R12
    .i_clock_phase_select      (act_fmt_reg[`SPM_FMT_CLOCK_PHASE_SELECT]), // R05 R06 R12
    .i_lead      (sck_lead),
    .i_trail     (sck_trail),
    .i_miso_s    (miso_s2_reg),
    .o_mosi      (o_mosi),
    .o_rx_data   (rx_data)
  );

endmodule

`default_nettype wire

// >>> logic/spm_sck_gen.v
`timescale 1ns/1ps
`default_nettype none

// Produces one byte worth of serial clock: eight leading and eight trailing edges.
module spm_sck_gen #(
  parameter integer HALF_CYC = 6
) (
  // Clock and control
  input  wire       i_core_clk,
  input  wire       i_rst_n,
  input  wire       i_ce,
  // Byte request and clock shape
  input  wire       i_start,
  input  wire       i_clock_polarity_select,
  // Serial clock and edge strobes
  output wire       o_sck,
  output reg        o_lead,
  output reg        o_trail,
  output reg        o_done
);

  reg [31:0] cnt_reg;
  reg [4:0]  edges_reg;
  reg        act_reg;
  reg        busy_reg;

  assign o_sck = act_reg ^ i_clock_polarity_select; // R07

  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cnt_reg   <= 32'h0;
      edges_reg <= 5'h00;
      act_reg   <= 1'b0;
      busy_reg  <= 1'b0;
      o_lead    <= 1'b0;
      o_trail   <= 1'b0;
      o_done    <= 1'b0;
    end else if (i_ce) begin
      o_lead  <= 1'b0;
      o_trail <= 1'b0;
      o_done  <= 1'b0;
      if (i_start && !busy_reg) begin
        busy_reg  <= 1'b1;
        cnt_reg   <= 32'h0;
        edges_reg <= 5'h00;
      end else if (busy_reg) begin
        if (cnt_reg == HALF_CYC - 1) begin
          cnt_reg   <= 32'h0;
          act_reg   <= ~act_reg;
          o_lead    <= ~act_reg;
          o_trail   <= act_reg;
          edges_reg <= edges_reg + 5'h01;
          if (edges_reg == 5'h0f) begin
            busy_reg <= 1'b0;
            o_done   <= 1'b1;
          end
        end else begin
          cnt_reg <= cnt_reg + 32'h1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> logic/spm_shifter.v
`timescale 1ns/1ps
`default_nettype none

module spm_shifter (
  // Clock and control
  input  wire       i_core_clk,
  input  wire       i_rst_n,
  input  wire       i_ce,
  // Byte load and frame format
  input  wire       i_load,
  input  wire [7:0] i_data,
  input  wire       i_lsb_first,
  input  wire       i_clock_phase_select,
  // Edge strobes and synchronised serial input
  input  wire       i_lead,
  input  wire       i_trail,
  input  wire       i_miso_s,
  // Serial output and received byte
  output reg        o_mosi,
  output reg  [7:0] o_rx_data
);

  reg [7:0] tx_sh_reg;

  function head_bit;
    input [7:0] d;
    input       lsb;
    begin
      head_bit = lsb ? d[0] : d[7];
    end
  endfunction

  function [7:0] drop_head;
    input [7:0] d;
    input       lsb;
    begin
      drop_head = lsb ? {1'b0, d[7:1]} : {d[6:0], 1'b0};
    end
  endfunction

  wire change_edge = i_clock_phase_select ? i_lead : i_trail; // R05 R06
  wire sample_edge = i_clock_phase_select ? i_trail : i_lead; // R05 R06

  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      tx_sh_reg <= 8'h00;
      o_mosi    <= 1'b0;
      o_rx_data <= 8'h00;
    end else if (i_ce) begin
      if (i_load) begin
        // With phase 0 the first bit must stand before the first leading edge.
        tx_sh_reg <= i_clock_phase_select ? i_data : drop_head(i_data, i_lsb_first); // R05 R06
        if (!i_clock_phase_select)
          o_mosi <= head_bit(i_data, i_lsb_first); // R03 R04
      end else if (change_edge) begin
        o_mosi    <= head_bit(tx_sh_reg, i_lsb_first); // R03 R04
        tx_sh_reg <= drop_head(tx_sh_reg, i_lsb_first);
      end
      if (sample_edge) begin
        o_rx_data <= i_lsb_first ? {i_miso_s, o_rx_data[7:1]} : {o_rx_data[6:0], i_miso_s}; // R04
      end
    end
  end

endmodule

`default_nettype wire

// >>> testbench/spm_chk.sv
`timescale 1ns/1ps
`default_nettype none
module spm_chk #(
  parameter integer HALF_CYC = 6
) (
  // Clock and reset
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  // Bus write path
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic        i_hready,
  // Fetch strobe and serial pins
  input wire logic        o_mem_rd,
  input wire logic        o_sck,
  input wire logic        o_mosi,
  input wire logic        o_cs_n
);
  logic       fmt_wr;
  logic [2:0] fmt_q;
  logic [2:0] fmt_a;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // Shadow of the format register, frozen while a frame is open.
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      fmt_wr <= 1'b0;
      fmt_q  <= 3'h0;
      fmt_a  <= 3'h0;
    end else begin
      fmt_wr <= i_hready && i_hsel && i_htrans[1] && i_hwrite && (i_haddr[11:2] == 10'h155);
      if (fmt_wr)
        fmt_q <= i_hwdata[2:0];
      if (o_cs_n)
        fmt_a <= fmt_q;
    end
  end
  sequence s_lead;
    $changed(o_sck) && (o_sck != fmt_a[2]);
  endsequence
  sequence s_trail;
    $changed(o_sck) && (o_sck == fmt_a[2]);
  endsequence
  a_sck_start_idle: assert property ($fell(o_cs_n) |-> o_sck == fmt_a[2])
    else $error("serial clock not at idle level as frame opens");
  a_sck_end_idle: assert property ($rose(o_cs_n) |-> o_sck == fmt_a[2])
    else $error("serial clock not at idle level as frame closes");
  a_sck_idle_out: assert property (o_cs_n |-> o_sck == fmt_q[2])
    else $error("serial clock off its idle level outside a frame");
  a_cs_min_low: assert property ($fell(o_cs_n) |-> !o_cs_n [*8])
    else $error("chip select frame too short");
  a_lead_still: assert property (!fmt_a[1] ##0 s_lead |-> $stable(o_mosi))
    else $error("data moved on leading edge in phase 0");
  a_trail_still: assert property (fmt_a[1] ##0 s_trail |-> $stable(o_mosi))
    else $error("data moved on trailing edge in phase 1");
  a_fetch_gap: assert property (o_mem_rd |=> !o_mem_rd [*8])
    else $error("fetch strobes too close");
  a_fetch_frame: assert property (o_mem_rd |-> !o_cs_n)
    else $error("fetch outside a frame");
endmodule
`default_nettype wire

// >>> testbench/spm_slave.sv
`timescale 1ns/1ps
`default_nettype none
module spm_slave (
  // Serial pins
  input  wire logic       i_sck,
  input  wire logic       i_cs_n,
  input  wire logic       i_mosi,
  output var  logic       o_miso,
  // Frame format and reply byte
  input  wire logic       i_clock_polarity_select,
  input  wire logic       i_clock_phase_select,
  input  wire logic       i_lsb,
  input  wire logic [7:0] i_tx
);
  logic [7:0] sh = 8'h00;
  logic [7:0] got[$];
  int         k = 0;
  int         j = 0;
  function automatic logic pick(input int n);
    return i_lsb ? i_tx[n % 8] : i_tx[7 - n % 8];
  endfunction
  initial o_miso = 1'b0;
  always @(negedge i_cs_n) begin
    k = 0;
    j = 0;
    if (!i_clock_phase_select) begin
      o_miso = pick(0);
      j = 1;
    end
  end
  // The released line has no pull, so it shows the inverse of its last level.
  always @(posedge i_cs_n) o_miso = ~o_miso;
  always @(i_sck) begin
    if (!i_cs_n) begin
      if ((i_sck != i_clock_polarity_select) ^ i_clock_phase_select) begin
        sh = i_lsb ? {i_mosi, sh[7:1]} : {sh[6:0], i_mosi};
        k++;
        if (k == 8) begin
          got.push_back(sh);
          k = 0;
        end
      end else begin
        o_miso = pick(j);
        j++;
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end
module testbench;
  localparam integer HC = 4;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] mem_addr;
  logic [7:0]  mem_rdata = 8'h00;
  logic [7:0]  stx = 8'h00;
  logic [2:0]  fmt = 3'h0;
  logic        hready, hresp, mem_rd, sck, mosi, cs_n, miso;
  int          n_fail = 0;
  int          tests_run = 0;
  int          seed = 17766;
  spm_master_regs #(.HALF_CYC(HC)) spm_master_regs_inst (.i_core_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .o_mem_addr(mem_addr),
    .o_mem_rd(mem_rd), .i_mem_rdata(mem_rdata), .o_sck(sck), .o_mosi(mosi), .o_cs_n(cs_n), .i_miso(miso));
  spm_slave spm_slave_inst (.i_sck(sck), .i_cs_n(cs_n), .i_mosi(mosi), .o_miso(miso), .i_clock_polarity_select(fmt[2]),
    .i_clock_phase_select(fmt[1]), .i_lsb(fmt[0]), .i_tx(stx));
  initial forever #2.5 clk = ~clk;
  // Transmit memory: one cycle latency, noise when not read.
  always @(posedge clk) mem_rdata <= mem_rd ? (mem_addr[7:0] ^ 8'h5a) : 8'($random(seed));
  task conclude;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task wait_rdy;
    int k;
    for (k = 0; k < 20 && hready !== 1'b1; k++) @(posedge clk);
    if (k == 20) begin
      n_fail++;
      conclude;
    end
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0, a};
    hwrite <= w;
    @(posedge clk);
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    wait_rdy;
    r = hrdata;
  endtask
  initial begin
    logic [31:0] r, ptr, e;
    logic [7:0]  overread_fill_char;
    int          len, lim, lst, t, i;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(0, 12'h54c, 0, r); `CHK("sent reset", 32'h0, r)
    bus(0, 12'h550, 0, r); `CHK("list reset", 32'h0, r)
    bus(0, 12'h554, 0, r); `CHK("format reset", 32'h0, r)
    bus(0, 12'h5c0, 0, r); `CHK("fill reset", 32'h0, r)
    bus(1, 12'h54c, 32'h7, r);
    bus(0, 12'h54c, 0, r); `CHK("sent read only", 32'h0, r)
    $display("test reset done");
    for (t = 0; t < 16; t++) begin
      fmt <= t[2:0];
      lst = $random(seed) & 1;
      len = 1 + {$random(seed)} % 5;
      lim = {$random(seed)} % 7;
      ptr = $random(seed);
      overread_fill_char = 8'($random(seed));
      stx <= 8'($random(seed));
      bus(1, 12'h554, {29'h0, t[2:0]}, r);
      bus(1, 12'h544, ptr, r);
      bus(1, 12'h548, 32'(lim), r);
      bus(1, 12'h508, 32'(len), r);
      bus(1, 12'h5c0, {24'h0, overread_fill_char}, r);
      bus(1, 12'h550, 32'(lst), r);
      bus(0, 12'h5c0, 0, r); `CHK("fill char", {24'h0, overread_fill_char}, r)
      spm_slave_inst.got.delete();
      bus(1, 12'h500, 32'h1, r);
      bus(0, 12'h504, 0, r); `CHK("busy", 32'h1, r)
      bus(1, 12'h554, {29'h0, ~t[2:0]}, r);
      bus(1, 12'h554, {29'h0, t[2:0]}, r);
      @(posedge clk);
      for (i = 0; i < 5000 && cs_n !== 1'b1; i++) @(posedge clk);
      if (i == 5000) begin
        n_fail++;
        conclude;
      end
      `CHK("byte count", len, spm_slave_inst.got.size())
      for (i = 0; i < len; i++) begin
        e = (i < lim) ? {24'h0, 8'(ptr + i) ^ 8'h5a} : {24'h0, overread_fill_char};
        `CHK("wire byte", e, {24'h0, spm_slave_inst.got[i]})
      end
      bus(0, 12'h54c, 0, r); `CHK("sent count", 32'(len < lim ? len : lim), r)
      bus(0, 12'h50c, 0, r); `CHK("received", {24'h0, stx}, r)
      bus(0, 12'h544, 0, r); `CHK("pointer", lst ? ptr + 32'(lim) : ptr, r)
      $display("test frame %0d done", t);
    end
    conclude;
  end
endmodule
bind spm_master_regs spm_chk #(.HALF_CYC(HALF_CYC)) spm_chk_inst (.i_core_clk, .i_rst_n, .i_hsel, .i_haddr,
  .i_htrans, .i_hwrite, .i_hwdata, .i_hready, .o_mem_rd, .o_sck, .o_mosi, .o_cs_n);
`default_nettype wire
